// file: rtl/btpsc_params.svh
`ifndef BTPSC_PARAMS_SVH
`define BTPSC_PARAMS_SVH

// System clock
`define BTPSC_CLK_MHZ          40

// Power-on reset settle time after the regulator enable is seen high
`define BTPSC_POR_SETTLE_NS    1000
`define BTPSC_POR_SETTLE_CYC   ((`BTPSC_POR_SETTLE_NS * `BTPSC_CLK_MHZ + 999) / 1000)
`define BTPSC_CNT_W            12

// Sniff/hold wake interval counter, in low-power clock ticks
`define BTPSC_WAKE_W           16
`define BTPSC_WAKE_ONE         16'h0001
`define BTPSC_WAKE_ZERO        16'h0000

// Wideband speech: linear 16-bit samples at 16 kHz
`define BTPSC_WBS_SAMPLE_BITS  16
`define BTPSC_WBS_RATE_HZ      16000
`define BTPSC_WBS_PERIOD_CYC   (`BTPSC_CLK_MHZ * 1000000 / `BTPSC_WBS_RATE_HZ)

// Reset levels
`define BTPSC_LVL_ON           1'b1
`define BTPSC_LVL_OFF          1'b0
`define BTPSC_CNT_ZERO         12'h000

`endif

// file: rtl/btpsc_pkg.sv
`include "btpsc_params.svh"

package btpsc_pkg;

    typedef enum logic [4:0] {
        ST_OFF      = 5'h01,
        ST_POR_WAIT = 5'h02,
        ST_ACTIVE   = 5'h04,
        ST_SLEEP    = 5'h08,
        ST_SHUTDOWN = 5'h10
    } btpsc_state_t;

    typedef logic [`BTPSC_WAKE_W-1:0] btpsc_wake_t;
    typedef logic [`BTPSC_CNT_W-1:0]  btpsc_cnt_t;

    // Core supply is up in these states; the core clock is enabled only in ST_ACTIVE
    function automatic logic btpsc_bt_powered(input btpsc_state_t st);
        return (st == ST_POR_WAIT) || (st == ST_ACTIVE) || (st == ST_SLEEP);
    endfunction

endpackage

// file: rtl/btpsc_wake_timer.sv
`timescale 1ns/1ps
`include "btpsc_params.svh"

module btpsc_wake_timer
    import btpsc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Control
    input  wire logic        load,
    input  wire logic        clear,
    input  wire btpsc_wake_t interval,
    input  wire logic        tick,
    // Status
    output logic             expired,
    output logic             busy
);

    btpsc_wake_t cnt_reg;
    btpsc_wake_t cnt_next;
    logic        busy_reg;
    logic        busy_next;
    logic        exp_reg;
    logic        exp_next;

    // Zero interval still waits one tick so the core never wakes in the same cycle
    wire btpsc_wake_t load_val = (interval == `BTPSC_WAKE_ZERO) ? `BTPSC_WAKE_ONE : interval;
    wire logic        last_tick = busy_reg && tick && (cnt_reg == `BTPSC_WAKE_ONE);

    always_comb begin
        cnt_next  = cnt_reg;
        busy_next = busy_reg;
        exp_next  = `BTPSC_LVL_OFF;
        if (clear) begin
            busy_next = `BTPSC_LVL_OFF;
        end else if (load) begin
            cnt_next  = load_val;
            busy_next = `BTPSC_LVL_ON;
        end else if (last_tick) begin
            busy_next = `BTPSC_LVL_OFF;
            exp_next  = `BTPSC_LVL_ON;
        end else if (busy_reg && tick) begin
            cnt_next = cnt_reg - `BTPSC_WAKE_ONE;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg  <= `BTPSC_WAKE_ZERO;
            busy_reg <= `BTPSC_LVL_OFF;
            exp_reg  <= `BTPSC_LVL_OFF;
        end else begin
            cnt_reg  <= cnt_next;
            busy_reg <= busy_next;
            exp_reg  <= exp_next;
        end
    end

    assign expired = exp_reg;
    assign busy    = busy_reg;

    ////////////////////////////////////////////////////////////////////////////
    property p_timer_expire;
        @(posedge clk) disable iff (rst)
        (busy_reg && tick && (cnt_reg == `BTPSC_WAKE_ONE) && !clear && !load) |=> expired && !busy;
    endproperty
    a_timer_expire: assert property (p_timer_expire) else $error("Wake timer missed its last tick");

    property p_timer_counts;
        @(posedge clk) disable iff (rst)
        (busy_reg && tick && (cnt_reg > `BTPSC_WAKE_ONE) && !clear && !load)
            |=> (cnt_reg == $past(cnt_reg) - `BTPSC_WAKE_ONE) && !expired;
    endproperty
    a_timer_counts: assert property (p_timer_counts) else $error("Wake timer failed to count down");

endmodule // btpsc_wake_timer

// file: rtl/btpsc_top.sv
`timescale 1ns/1ps
`include "btpsc_params.svh"

// What this block does
// - The Bluetooth power-on reset stays asserted while the regulator enable pin is low.
// - The power-on reset is released only after the regulator enable has gone high.
// - In sniff or hold the block runs from the low-power clock and wakes after its interval.
// - The RF sections are switched on and off around each transmitted and received packet.
// - Shutdown removes RF and core power but keeps I/O power present.
// - In shutdown every output is tristated and most inputs are disabled.
// - Leaving shutdown is a normal power-up with no state kept from before.
// - FM power is a single on/off control with no low-power state.
// - FM power can follow its own enable or run in tandem with the Bluetooth core.
// - Wideband speech uses 16-bit linear samples paced at 16 kHz on the PCM bus.
module btpsc_top
    import btpsc_pkg::*;
(
    // Clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RST,
    // Pins
    input  wire logic        BT_REGULATOR_ENABLE,
    input  wire logic        LOW_POWER_CLOCK_INPUT,
    // Baseband core requests
    input  wire logic        SLEEP_REQ,
    input  wire btpsc_wake_t SLEEP_INTERVAL,
    input  wire logic        SHUTDOWN_REQ,
    input  wire logic        TX_PKT_ACTIVE,
    input  wire logic        RX_PKT_ACTIVE,
    input  wire logic        FM_ENABLE,
    input  wire logic        FM_TANDEM,
    input  wire logic        WIDEBAND_SPEECH_ENABLE,
    // Reset and supply controls
    output logic             BT_POR_ACTIVE,
    output logic             CORE_POWER_EN,
    output logic             IO_POWER_EN,
    output logic             OUTPUT_ENABLE,
    output logic             INPUT_ENABLE,
    // Clocking
    output logic             CORE_CLOCK_EN,
    output logic             LPO_CLOCK_SELECT,
    output logic             WAKE_PULSE,
    // RF section
    output logic             RF_TX_EN,
    output logic             RF_RX_EN,
    output logic             RF_PLL_EN,
    output logic             RF_PA_EN,
    // FM and wideband speech
    output logic             FM_POWER_EN,
    output logic             WBS_CODEC_EN,
    output logic             WBS_SAMPLE_STROBE
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic en_meta_reg;
    logic en_sync_reg;
    logic lpo_meta_reg;
    logic lpo_sync_reg;
    logic lpo_prev_reg;

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            en_meta_reg  <= `BTPSC_LVL_OFF;
            en_sync_reg  <= `BTPSC_LVL_OFF;
            lpo_meta_reg <= `BTPSC_LVL_OFF;
            lpo_sync_reg <= `BTPSC_LVL_OFF;
            lpo_prev_reg <= `BTPSC_LVL_OFF;
        end else begin
            en_meta_reg  <= BT_REGULATOR_ENABLE;
            en_sync_reg  <= en_meta_reg;
            lpo_meta_reg <= LOW_POWER_CLOCK_INPUT;
            lpo_sync_reg <= lpo_meta_reg;
            lpo_prev_reg <= lpo_sync_reg;
        end
    end

    wire logic lpo_tick = lpo_sync_reg && !lpo_prev_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Power state machine
    btpsc_state_t state_reg;
    btpsc_state_t state_next;
    btpsc_cnt_t   settle_reg;
    logic         timer_expired;
    logic         timer_busy;

    wire logic settle_done = (settle_reg == btpsc_cnt_t'(`BTPSC_POR_SETTLE_CYC - 1));
    // Shutdown disables most inputs: only the shutdown request, the FM controls and the pins are heard
    wire logic sleep_go    = SLEEP_REQ && !SHUTDOWN_REQ;

    always_comb begin
        state_next = state_reg;
        if (!en_sync_reg) begin
            state_next = ST_OFF;
        end else begin
            case (state_reg)
                ST_OFF:      state_next = ST_POR_WAIT;
                ST_POR_WAIT: if (settle_done) state_next = ST_ACTIVE;
                ST_ACTIVE: begin
                    if (SHUTDOWN_REQ)  state_next = ST_SHUTDOWN;
                    else if (sleep_go) state_next = ST_SLEEP;
                end
                ST_SLEEP: begin
                    if (SHUTDOWN_REQ)       state_next = ST_SHUTDOWN;
                    else if (timer_expired) state_next = ST_ACTIVE;
                end
                // Exit always passes the full power-up path, so nothing survives
                ST_SHUTDOWN: if (!SHUTDOWN_REQ) state_next = ST_OFF;
                default:     state_next = ST_OFF;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            state_reg  <= ST_OFF;
            settle_reg <= `BTPSC_CNT_ZERO;
        end else begin
            state_reg  <= state_next;
            settle_reg <= (state_reg == ST_POR_WAIT) ? settle_reg + 1'b1 : `BTPSC_CNT_ZERO;
        end
    end

    wire logic timer_load  = (state_reg == ST_ACTIVE) && (state_next == ST_SLEEP);
    wire logic timer_clear = (state_reg == ST_SLEEP) && (state_next != ST_SLEEP);

    btpsc_wake_timer u_wake_timer (
        .clk      (SYS_CLK),
        .rst      (RST),
        .load     (timer_load),
        .clear    (timer_clear),
        .interval (SLEEP_INTERVAL),
        .tick     (lpo_tick),
        .expired  (timer_expired),
        .busy     (timer_busy)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Output decode from the next state, so every output except the constant IO_POWER_EN is a flip-flop
    wire logic nx_active   = (state_next == ST_ACTIVE);
    wire logic nx_shutdown = (state_next == ST_SHUTDOWN);
    wire logic nx_powered  = btpsc_bt_powered(state_next);
    wire logic nx_por      = !nx_active && (state_next != ST_SLEEP);
    wire logic nx_tx       = nx_active && TX_PKT_ACTIVE;
    wire logic nx_rx       = nx_active && RX_PKT_ACTIVE;
    wire logic nx_fm       = FM_ENABLE && (!FM_TANDEM || nx_powered);
    wire logic nx_wake     = (state_reg == ST_SLEEP) && nx_active;
    wire logic nx_wbs      = nx_active && WIDEBAND_SPEECH_ENABLE;

    logic por_reg;
    logic core_pwr_reg;
    logic io_en_reg;
    logic core_clk_reg;
    logic lpo_sel_reg;
    logic wake_reg;
    logic tx_reg;
    logic rx_reg;
    logic pll_reg;
    logic pa_reg;
    logic fm_reg;
    logic wbs_en_reg;
    logic wbs_stb_reg;
    btpsc_cnt_t wbs_cnt_reg;

    wire logic wbs_wrap = (wbs_cnt_reg == btpsc_cnt_t'(`BTPSC_WBS_PERIOD_CYC - 1));

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            por_reg      <= `BTPSC_LVL_ON;
            core_pwr_reg <= `BTPSC_LVL_OFF;
            io_en_reg    <= `BTPSC_LVL_ON;
            core_clk_reg <= `BTPSC_LVL_OFF;
            lpo_sel_reg  <= `BTPSC_LVL_OFF;
            wake_reg     <= `BTPSC_LVL_OFF;
            tx_reg       <= `BTPSC_LVL_OFF;
            rx_reg       <= `BTPSC_LVL_OFF;
            pll_reg      <= `BTPSC_LVL_OFF;
            pa_reg       <= `BTPSC_LVL_OFF;
            fm_reg       <= `BTPSC_LVL_OFF;
            wbs_en_reg   <= `BTPSC_LVL_OFF;
        end else begin
            por_reg      <= nx_por;
            core_pwr_reg <= nx_powered;
            io_en_reg    <= !nx_shutdown;
            core_clk_reg <= nx_active;
            lpo_sel_reg  <= (state_next == ST_SLEEP);
            wake_reg     <= nx_wake;
            tx_reg       <= nx_tx;
            rx_reg       <= nx_rx;
            pll_reg      <= nx_tx || nx_rx;
            pa_reg       <= nx_tx;
            fm_reg       <= nx_fm;
            wbs_en_reg   <= nx_wbs;
        end
    end

    // Sample pacing restarts from zero each time the codec is enabled
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            wbs_cnt_reg <= `BTPSC_CNT_ZERO;
            wbs_stb_reg <= `BTPSC_LVL_OFF;
        end else begin
            wbs_cnt_reg <= (!nx_wbs || wbs_wrap) ? `BTPSC_CNT_ZERO : wbs_cnt_reg + 1'b1;
            wbs_stb_reg <= nx_wbs && wbs_wrap;
        end
    end

    assign BT_POR_ACTIVE     = por_reg;
    assign CORE_POWER_EN     = core_pwr_reg;
    // I/O supply is never removed by this block
    assign IO_POWER_EN       = `BTPSC_LVL_ON;
    assign OUTPUT_ENABLE     = io_en_reg;
    assign INPUT_ENABLE      = io_en_reg;
    assign CORE_CLOCK_EN     = core_clk_reg;
    assign LPO_CLOCK_SELECT  = lpo_sel_reg;
    assign WAKE_PULSE        = wake_reg;
    assign RF_TX_EN          = tx_reg;
    assign RF_RX_EN          = rx_reg;
    assign RF_PLL_EN         = pll_reg;
    assign RF_PA_EN          = pa_reg;
    assign FM_POWER_EN       = fm_reg;
    assign WBS_CODEC_EN      = wbs_en_reg;
    assign WBS_SAMPLE_STROBE = wbs_stb_reg;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    property p_por_held;
        !en_sync_reg |=> BT_POR_ACTIVE && !CORE_POWER_EN;
    endproperty
    a_por_held: assert property (p_por_held) else $error("Reset released with enable low");

    property p_por_release;
        $fell(BT_POR_ACTIVE) |-> $past(en_sync_reg) && $past(state_reg) == ST_POR_WAIT;
    endproperty
    a_por_release: assert property (p_por_release) else $error("Reset released too early");

    property p_sleep_lpo;
        (state_reg == ST_SLEEP) |-> LPO_CLOCK_SELECT && !CORE_CLOCK_EN && !RF_PLL_EN;
    endproperty
    a_sleep_lpo: assert property (p_sleep_lpo) else $error("Sleep not on low-power clock");

    property p_wake;
        (state_reg == ST_SLEEP) && timer_expired && en_sync_reg && !SHUTDOWN_REQ
            |=> WAKE_PULSE && CORE_CLOCK_EN ##1 !WAKE_PULSE;
    endproperty
    a_wake: assert property (p_wake) else $error("No wake on interval expiry");

    property p_rf_follow;
        (state_next == ST_ACTIVE) |=> (RF_TX_EN == $past(TX_PKT_ACTIVE))
            && (RF_RX_EN == $past(RX_PKT_ACTIVE)) && (RF_PLL_EN == (RF_TX_EN || RF_RX_EN));
    endproperty
    a_rf_follow: assert property (p_rf_follow) else $error("RF gating lost packet timing");

    property p_shutdown_power;
        (state_reg == ST_SHUTDOWN) |-> !CORE_POWER_EN && !RF_PLL_EN && IO_POWER_EN;
    endproperty
    a_shutdown_power: assert property (p_shutdown_power) else $error("Shutdown supplies wrong");

    property p_shutdown_hiz;
        (state_reg == ST_SHUTDOWN) |-> !OUTPUT_ENABLE && !INPUT_ENABLE;
    endproperty
    a_shutdown_hiz: assert property (p_shutdown_hiz) else $error("Pins live in shutdown");

    property p_shutdown_exit;
        (state_reg == ST_SHUTDOWN) && (state_next != ST_SHUTDOWN)
            |=> BT_POR_ACTIVE ##1 BT_POR_ACTIVE && !timer_busy;
    endproperty
    a_shutdown_exit: assert property (p_shutdown_exit) else $error("Shutdown exit skipped reset");

    property p_fm;
        FM_ENABLE && !FM_TANDEM |=> FM_POWER_EN;
    endproperty
    a_fm: assert property (p_fm) else $error("Independent FM not powered");

    property p_wbs;
        WBS_SAMPLE_STROBE |=> !WBS_SAMPLE_STROBE [*8];
    endproperty
    a_wbs: assert property (p_wbs) else $error("Sample strobes too close");

    c_powerup:  cover property ($fell(BT_POR_ACTIVE));
    c_wake:     cover property (WAKE_PULSE);
    c_shutdown: cover property ((state_reg == ST_SHUTDOWN) ##1 (state_reg == ST_OFF));
    c_tx_pkt:   cover property ($rose(RF_TX_EN) ##[1:20] $fell(RF_TX_EN));

endmodule // btpsc_top

// file: test/btpsc_host_model.sv
`timescale 1ns/1ps

module btpsc_host_model #(
    parameter int IO_CFG_CYC = 5,
    parameter int LPO_HALF   = 8
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Bench controls
    input  wire logic pwr_req,
    input  wire logic lpo_run,
    // Pins toward the device
    output logic      reg_en,
    output logic      lpo_clk,
    output logic      io_ready
);
    int cfg_cnt;
    int lpo_cnt;

    ////////////////////////////////////////////////////////////////////////////////
    // The host sets up its own lines before it lets the device power up
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_cnt  <= 0;
            io_ready <= 1'b0;
            reg_en   <= 1'b0;
        end else if (!pwr_req) begin
            cfg_cnt  <= 0;
            io_ready <= 1'b0;
            reg_en   <= 1'b0;
        end else if (cfg_cnt < IO_CFG_CYC) begin
            cfg_cnt <= cfg_cnt + 1;
        end else begin
            io_ready <= 1'b1;
            reg_en   <= io_ready;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Slow clock stands still when not wanted, so no tick leaks in before sleep
    always_ff @(posedge clk or posedge rst) begin
        if (rst || !lpo_run) begin
            lpo_cnt <= 0;
            lpo_clk <= 1'b0;
        end else if (lpo_cnt == LPO_HALF - 1) begin
            lpo_cnt <= 0;
            lpo_clk <= ~lpo_clk;
        end else begin
            lpo_cnt <= lpo_cnt + 1;
        end
    end
endmodule // btpsc_host_model

// file: test/btpsc_top_tb.sv
`timescale 1ns/1ps

module btpsc_top_tb
    import btpsc_pkg::*;
;
    logic        sys_clk, rst, pwr_req, lpo_run, sleep_req, shut_req;
    logic        tx_pkt, rx_pkt, fm_en, fm_tan, wbs_en;
    btpsc_wake_t interval;
    logic        reg_en, lpo_clk, io_ready;
    logic        por, core_pwr, io_pwr, out_en, in_en, core_clk, lpo_sel, wake;
    logic        rf_tx, rf_rx, rf_pll, rf_pa, fm_pwr, wbs_on, wbs_stb;
    int          error_cnt, checks, seed, n;
    logic [1:0]  rf_q[$];

    btpsc_host_model u_host (.clk(sys_clk), .rst(rst), .pwr_req(pwr_req), .lpo_run(lpo_run),
        .reg_en(reg_en), .lpo_clk(lpo_clk), .io_ready(io_ready));

    btpsc_top u_dut (.SYS_CLK(sys_clk), .RST(rst), .BT_REGULATOR_ENABLE(reg_en),
        .LOW_POWER_CLOCK_INPUT(lpo_clk), .SLEEP_REQ(sleep_req), .SLEEP_INTERVAL(interval),
        .SHUTDOWN_REQ(shut_req), .TX_PKT_ACTIVE(tx_pkt), .RX_PKT_ACTIVE(rx_pkt),
        .FM_ENABLE(fm_en), .FM_TANDEM(fm_tan), .WIDEBAND_SPEECH_ENABLE(wbs_en),
        .BT_POR_ACTIVE(por), .CORE_POWER_EN(core_pwr), .IO_POWER_EN(io_pwr),
        .OUTPUT_ENABLE(out_en), .INPUT_ENABLE(in_en), .CORE_CLOCK_EN(core_clk),
        .LPO_CLOCK_SELECT(lpo_sel), .WAKE_PULSE(wake), .RF_TX_EN(rf_tx), .RF_RX_EN(rf_rx),
        .RF_PLL_EN(rf_pll), .RF_PA_EN(rf_pa), .FM_POWER_EN(fm_pwr), .WBS_CODEC_EN(wbs_on),
        .WBS_SAMPLE_STROBE(wbs_stb));

    ////////////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task test_done;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task bound(input int cnt, input int lim);
        if (cnt >= lim) begin
            error_cnt++;
            $display("wait limit reached at %0t", $time);
            test_done();
        end
    endtask

    // Settle window is loose by design: the exact edge depends on synchroniser phase
    task wait_por(input int lo, input int hi);
        n = 0;
        while (por !== 1'b0 && n < 200) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        bound(n, 200);
        chk(n >= lo && n <= hi, 32'h1);
    endtask

    task power_up;
        logic rdy;
        @(posedge sys_clk);
        pwr_req <= 1'b1;
        n = 0;
        do begin
            rdy = io_ready;
            @(posedge sys_clk);
            #1;
            n++;
        end while (reg_en !== 1'b1 && n < 50);
        bound(n, 50);
        // Host lines must already be set up in the cycle before the enable rises
        chk(rdy, 1'b1);
        chk(por, 1'b1);
        wait_por(42, 46);
        chk({core_clk, out_en, core_pwr}, 3'h7);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task rf_run;
        bit         t, r;
        logic [1:0] e;
        for (int i = 0; i < 40; i++) begin
            t = 1'($random(seed));
            r = 1'($random(seed));
            @(posedge sys_clk);
            tx_pkt <= t;
            rx_pkt <= r;
            #1;
            if (i > 0) begin
                e = rf_q.pop_front();
                chk({rf_tx, rf_rx, rf_pll, rf_pa}, {e[1], e[0], |e, e[1]});
            end
            rf_q.push_back({t, r});
        end
        @(posedge sys_clk);
        tx_pkt <= 1'b0;
        rx_pkt <= 1'b0;
        rf_q.delete();
        repeat (2) @(posedge sys_clk);
    endtask

    task fm_case(input logic en, input logic tan, input logic core);
        @(posedge sys_clk);
        fm_en  <= en;
        fm_tan <= tan;
        repeat (2) @(posedge sys_clk);
        #1;
        chk(fm_pwr, en && (!tan || core));
    endtask

    task sleep_run(input btpsc_wake_t iv);
        int   ex, t;
        logic prev;
        ex = (iv == 16'h0000) ? 1 : int'(iv);
        @(posedge sys_clk);
        sleep_req <= 1'b1;
        interval  <= iv;
        @(posedge sys_clk);
        sleep_req <= 1'b0;
        @(posedge sys_clk);
        lpo_run <= 1'b1;
        #1;
        chk({lpo_sel, core_clk}, 2'h2);
        t = 0;
        prev = 1'b0;
        n = 0;
        while (wake !== 1'b1 && n < 2000) begin
            @(posedge sys_clk);
            #1;
            n++;
            if (lpo_clk && !prev) t++;
            prev = lpo_clk;
        end
        bound(n, 2000);
        chk(t, ex);
        chk({core_clk, lpo_sel}, 2'h2);
        @(posedge sys_clk);
        lpo_run <= 1'b0;
        #1;
        chk(wake, 1'b0);
    endtask

    task wait_stb;
        n = 0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (wbs_stb !== 1'b1 && n < 3000);
        bound(n, 3000);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (100000) @(posedge sys_clk);
        error_cnt++;
        test_done();
    end

    initial begin
        seed = 2;
        error_cnt = 0;
        checks = 0;
        {rst, pwr_req, lpo_run, sleep_req, shut_req} = 5'h10;
        {tx_pkt, rx_pkt, fm_en, fm_tan, wbs_en} = 5'h00;
        interval = 16'h0000;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk({por, io_pwr, out_en, core_pwr}, 4'hE);
        $display("test reset done");
        power_up();
        $display("test power up done");
        rf_run();
        $display("test rf gating done");
        for (int k = 0; k < 4; k++) fm_case(k[1], k[0], 1'b1);
        $display("test fm active done");
        sleep_run(16'h0000);
        sleep_run(16'h0001);
        sleep_run(16'h0003);
        sleep_run(btpsc_wake_t'(2 + ($unsigned($random(seed)) % 5)));
        $display("test sleep done");
        @(posedge sys_clk);
        wbs_en <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        chk(wbs_on, 1'b1);
        wait_stb();
        wait_stb();
        chk(n, 2500);
        @(posedge sys_clk);
        #1;
        chk(wbs_stb, 1'b0);
        $display("test speech pacing done");
        // Sleep and packet requests ride along to prove shutdown ignores them
        @(posedge sys_clk);
        shut_req  <= 1'b1;
        sleep_req <= 1'b1;
        tx_pkt    <= 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        chk({core_pwr, out_en, in_en, por, io_pwr}, 5'h03);
        chk({lpo_sel, rf_tx, wbs_on}, 3'h0);
        fm_case(1'b1, 1'b1, 1'b0);
        fm_case(1'b1, 1'b0, 1'b0);
        @(posedge sys_clk);
        shut_req  <= 1'b0;
        sleep_req <= 1'b0;
        tx_pkt    <= 1'b0;
        wait_por(41, 46);
        chk({core_clk, out_en, in_en, lpo_sel}, 4'hE);
        $display("test shutdown done");
        @(posedge sys_clk);
        pwr_req <= 1'b0;
        n = 0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (por !== 1'b1 && n < 10);
        bound(n, 10);
        chk(n <= 6, 32'h1);
        repeat (20) begin
            @(posedge sys_clk);
            #1;
            chk({por, core_pwr}, 2'h2);
        end
        $display("test power off done");
        test_done();
    end
endmodule // btpsc_top_tb
